/* sps_params.svh */
// constants for the speed/position switching axis
// Operation
// - switch active on input on (NO) or off (NC)
// - update request off: clear feed, then track
// - update request on: keep feed, stroke stop
// - travel value changeable during speed mode
// - travel is two words, axis stride twenty
// - small variant: axes one to eight only
// - store travel since position mode selected
// - switch needs accept, speed mode, enable
// - enable and switch at start: position only
// - short travel: decelerate at once on switch
// - short travel: error flag, code 209
// - short travel: no positioning complete flag
// - no stroke check in speed mode
// - stroke exceeded at switch: code 210, stop
// - switch honoured only with enable on
// - forward increases address, reverse decreases
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
// ==========================================
// register indices, byte address is four times
`define IDX_TRAVEL_BASE 11'h010
`define IDX_TRAVEL_STRIDE 11'h014
`define IDX_CTRL 11'h400
`define IDX_CMD 11'h401
`define IDX_STATUS 11'h402
`define IDX_SPEED 11'h403
`define IDX_STROKE_HI 11'h404
`define IDX_STROKE_LO 11'h405
`define IDX_FEED 11'h406
`define IDX_POSTPROX 11'h407
`define IDX_ERRCODE 11'h408
`define IDX_IRQ_STAT 11'h409
`define IDX_IRQ_MASK 11'h40A
// ==========================================
// field positions
`define CTRL_NC 0
`define CTRL_ENABLE 1
`define CTRL_UPDATE 2
`define CMD_FWD 0
`define CMD_REV 1
`define CMD_STOP 2
`define CMD_ERRCLR 3
`define EV_SWITCH 0
`define EV_DONE 1
`define EV_OVERRUN 2
`define EV_STROKE 3
// ==========================================
// reset values and codes
`define SPEED_RST 16'h0010
`define STROKE_HI_RST 32'h7FFFFFFF
`define STROKE_LO_RST 32'h80000000
`define ERR_OVERRUN 16'd209
`define ERR_STROKE 16'd210
`define SMALL_AXES 8
// ==========================================
// control cycle timing
`define CLK_MHZ 125
`define CTRL_PERIOD_NS 1000
`define CTRL_CYCLES ((`CTRL_PERIOD_NS * `CLK_MHZ) / 1000)
`endif

/* sps_pkg.sv */
// types shared by the speed/position switching axis
package sps_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SPEED = 2'b01,
        ST_POSITION = 2'b10,
        ST_DECEL = 2'b11
    } axis_state_e;
endpackage

/* sticky_bits.sv */
// sticky status bits, set by events, cleared by writing one
`timescale 1ns/10ps
module sticky_bits #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] stat
);
    typedef struct packed {
        logic [WIDTH-1:0] bits;
    } sticky_s;

    sticky_s st_r;
    sticky_s st_nxt;

    // set wins over a clear in the same cycle
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.bits = (st_r.bits & ~clr) | set;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign stat = st_r.bits;
endmodule // sticky_bits

/* sps_axis.sv */
// speed/position switching axis with wishbone register access
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_axis
    import sps_pkg::*;
#(
    parameter int AXIS_NUM = 1,
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic change_in,
    output logic start_accept_flag,
    output logic speed_controlling_flag,
    output logic positioning_complete_flag,
    output logic error_detection_flag,
    output logic [15:0] servo_step,
    output logic servo_dir,
    output logic irq
);
    localparam int TRAVEL_LO = `IDX_TRAVEL_BASE + `IDX_TRAVEL_STRIDE * (AXIS_NUM - 1);
    localparam bit TRAVEL_OK = LARGE_VARIANT || (AXIS_NUM <= `SMALL_AXES);
    localparam logic [7:0] TICK_LAST = 8'(`CTRL_CYCLES - 1);

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [2:0] ctrl;
        logic [15:0] speed_cmd;
        logic [31:0] stroke_hi;
        logic [31:0] stroke_lo;
        logic [31:0] travel;
        axis_state_e state;
        logic dir;
        logic keep_feed;
        logic [7:0] tick_cnt;
        logic sw_prev;
        logic [15:0] cur_spd;
        logic [31:0] rem;
        logic [31:0] feed;
        logic [31:0] postprox;
        logic [15:0] err_code;
        logic err_flag;
        logic done_flag;
        logic spd_flag;
        logic [15:0] step;
        logic [3:0] irq_mask;
        logic irq;
        logic accept;
    } axis_s;

    axis_s st_r;
    axis_s st_nxt;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic [3:0] irq_stat;

    // ==========================================
    // bus decode
    logic [10:0] idx;
    logic req;
    logic wr;
    logic [31:0] wmask;
    logic tick;
    logic sw_act;
    logic sw_edge;
    logic [31:0] dec_dist;
    logic signed [32:0] target;
    logic out_of_stroke;
    logic [15:0] step_now;
    logic [31:0] feed_adv;

    assign idx = wb_adr_i[12:2];
    assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign wr = req && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign tick = (st_r.tick_cnt == TICK_LAST);
    assign sw_act = st_r.ctrl[`CTRL_NC] ? !change_in : change_in;
    assign sw_edge = tick && sw_act && !st_r.sw_prev;
    assign dec_dist = ({16'h0000, st_r.cur_spd} * {16'h0000, st_r.cur_spd}) >> 1;
    assign target = st_r.dir ? $signed({st_r.feed[31], st_r.feed}) - $signed({1'b0, st_r.travel})
                              : $signed({st_r.feed[31], st_r.feed}) + $signed({1'b0, st_r.travel});
    assign out_of_stroke = (target > $signed({st_r.stroke_hi[31], st_r.stroke_hi}))
                        || (target < $signed({st_r.stroke_lo[31], st_r.stroke_lo}));
    assign ev_clr = (wr && idx == `IDX_IRQ_STAT) ? wb_dat_i[3:0] & wmask[3:0] : 4'h0;

    function automatic logic [31:0] wmerge(input logic [31:0] old);
        wmerge = (old & ~wmask) | (wb_dat_i & wmask);
    endfunction
    // narrow registers take the low half of the data bus
    function automatic logic [15:0] wmerge16(input logic [15:0] old);
        wmerge16 = (old & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        ev_set = 4'h0;
        step_now = 16'h0000;
        feed_adv = st_r.feed;
        // ==========================================
        // register access, one-cycle answer
        st_nxt.ack = req;
        if (req)
        begin
            if (TRAVEL_OK && idx == 11'(TRAVEL_LO))
                st_nxt.rdat = st_r.travel & 32'h0000FFFF;
            else if (TRAVEL_OK && idx == 11'(TRAVEL_LO + 1))
                st_nxt.rdat = {16'h0000, st_r.travel[31:16]};
            else if (idx == `IDX_CTRL)
                st_nxt.rdat = {29'h0, st_r.ctrl};
            else if (idx == `IDX_STATUS)
                st_nxt.rdat = {25'h0, st_r.state, st_r.dir, st_r.err_flag,
                               st_r.done_flag, st_r.spd_flag, st_r.state != ST_IDLE};
            else if (idx == `IDX_SPEED)
                st_nxt.rdat = {16'h0000, st_r.speed_cmd};
            else if (idx == `IDX_STROKE_HI)
                st_nxt.rdat = st_r.stroke_hi;
            else if (idx == `IDX_STROKE_LO)
                st_nxt.rdat = st_r.stroke_lo;
            else if (idx == `IDX_FEED)
                st_nxt.rdat = st_r.feed;
            else if (idx == `IDX_POSTPROX)
                st_nxt.rdat = st_r.postprox;
            else if (idx == `IDX_ERRCODE)
                st_nxt.rdat = {16'h0000, st_r.err_code};
            else if (idx == `IDX_IRQ_STAT)
                st_nxt.rdat = {28'h0, irq_stat};
            else if (idx == `IDX_IRQ_MASK)
                st_nxt.rdat = {28'h0, st_r.irq_mask};
            else
                st_nxt.rdat = 32'h00000000;
        end
        if (wr)
        begin
            // latest travel value is used at the switch
            if (TRAVEL_OK && idx == 11'(TRAVEL_LO))
                st_nxt.travel[15:0] = wmerge16(st_r.travel[15:0]);
            else if (TRAVEL_OK && idx == 11'(TRAVEL_LO + 1))
                st_nxt.travel[31:16] = wmerge16(st_r.travel[31:16]);
            else if (idx == `IDX_CTRL)
                st_nxt.ctrl = 3'(wmerge16({13'h0000, st_r.ctrl}));
            else if (idx == `IDX_SPEED)
                st_nxt.speed_cmd = wmerge16(st_r.speed_cmd);
            else if (idx == `IDX_STROKE_HI)
                st_nxt.stroke_hi = wmerge(st_r.stroke_hi);
            else if (idx == `IDX_STROKE_LO)
                st_nxt.stroke_lo = wmerge(st_r.stroke_lo);
            else if (idx == `IDX_IRQ_MASK)
                st_nxt.irq_mask = 4'(wmerge16({12'h000, st_r.irq_mask}));
        end
        if (wr && idx == `IDX_CMD && wb_sel_i[0] && wb_dat_i[`CMD_ERRCLR])
            st_nxt.err_flag = 1'b0;
        // ==========================================
        // control cycle
        st_nxt.tick_cnt = tick ? 8'h00 : st_r.tick_cnt + 8'h01;
        if (tick)
            st_nxt.sw_prev = sw_act;
        case (st_r.state)
            ST_IDLE:
            begin
                st_nxt.step = 16'h0000;
                if (wr && idx == `IDX_CMD && wb_sel_i[0]
                    && (wb_dat_i[`CMD_FWD] || wb_dat_i[`CMD_REV]))
                begin
                    st_nxt.dir = !wb_dat_i[`CMD_FWD];
                    st_nxt.keep_feed = st_r.ctrl[`CTRL_UPDATE];
                    if (!st_r.ctrl[`CTRL_UPDATE])
                        st_nxt.feed = 32'h00000000;
                    st_nxt.cur_spd = st_r.speed_cmd;
                    st_nxt.done_flag = 1'b0;
                    st_nxt.sw_prev = sw_act;
                    if (st_r.ctrl[`CTRL_ENABLE] && sw_act)
                    begin
                        st_nxt.state = ST_POSITION;
                        st_nxt.rem = st_r.travel;
                        st_nxt.postprox = 32'h00000000;
                        st_nxt.spd_flag = 1'b0;
                    end
                    else
                    begin
                        st_nxt.state = ST_SPEED;
                        st_nxt.spd_flag = 1'b1;
                    end
                end
            end
            ST_SPEED:
            begin
                if (tick)
                begin
                    step_now = st_r.cur_spd;
                    // enable must be on at the edge itself
                    if (sw_edge && st_r.ctrl[`CTRL_ENABLE])
                    begin
                        st_nxt.spd_flag = 1'b0;
                        st_nxt.postprox = 32'h00000000;
                        ev_set[`EV_SWITCH] = 1'b1;
                        if (out_of_stroke)
                        begin
                            st_nxt.state = ST_DECEL;
                            st_nxt.err_code = `ERR_STROKE;
                            st_nxt.err_flag = 1'b1;
                            ev_set[`EV_STROKE] = 1'b1;
                        end
                        else if (st_r.travel < dec_dist)
                        begin
                            st_nxt.state = ST_DECEL;
                            st_nxt.err_code = `ERR_OVERRUN;
                            st_nxt.err_flag = 1'b1;
                            ev_set[`EV_OVERRUN] = 1'b1;
                        end
                        else
                        begin
                            st_nxt.state = ST_POSITION;
                            st_nxt.rem = st_r.travel;
                        end
                    end
                end
            end
            ST_POSITION:
            begin
                if (tick)
                begin
                    if (dec_dist >= st_r.rem && st_r.cur_spd > 16'h0001)
                        st_nxt.cur_spd = st_r.cur_spd - 16'h0001;
                    step_now = (32'(st_r.cur_spd) > st_r.rem) ? st_r.rem[15:0] : st_r.cur_spd;
                    st_nxt.rem = st_r.rem - 32'(step_now);
                    st_nxt.postprox = st_r.postprox + 32'(step_now);
                    if (st_r.rem == 32'(step_now))
                    begin
                        st_nxt.state = ST_IDLE;
                        st_nxt.done_flag = 1'b1;
                        ev_set[`EV_DONE] = 1'b1;
                    end
                end
            end
            ST_DECEL:
            begin
                if (tick)
                begin
                    step_now = st_r.cur_spd;
                    st_nxt.postprox = st_r.postprox + 32'(step_now);
                    if (st_r.cur_spd == 16'h0000)
                        st_nxt.state = ST_IDLE;
                    else
                        st_nxt.cur_spd = st_r.cur_spd - 16'h0001;
                end
            end
            default:
                st_nxt.state = ST_IDLE;
        endcase
        // ==========================================
        // feed current value and stop handling
        if (tick && st_r.state != ST_IDLE)
        begin
            feed_adv = st_r.dir ? st_r.feed - 32'(step_now) : st_r.feed + 32'(step_now);
            st_nxt.feed = feed_adv;
            st_nxt.step = step_now;
            if (st_r.state == ST_POSITION && st_r.keep_feed && st_nxt.state == ST_POSITION
                && ($signed(feed_adv) > $signed(st_r.stroke_hi)
                    || $signed(feed_adv) < $signed(st_r.stroke_lo)))
            begin
                st_nxt.state = ST_DECEL;
                st_nxt.err_code = `ERR_STROKE;
                st_nxt.err_flag = 1'b1;
                ev_set[`EV_STROKE] = 1'b1;
            end
        end
        if (wr && idx == `IDX_CMD && wb_sel_i[0] && wb_dat_i[`CMD_STOP]
            && (st_r.state == ST_SPEED || st_r.state == ST_POSITION))
        begin
            st_nxt.state = ST_DECEL;
            st_nxt.spd_flag = 1'b0;
        end
        st_nxt.accept = (st_nxt.state != ST_IDLE);
        st_nxt.irq = |(irq_stat & st_r.irq_mask);
    end

    // ==========================================
    // state register
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.speed_cmd <= `SPEED_RST;
            st_r.stroke_hi <= `STROKE_HI_RST;
            st_r.stroke_lo <= `STROKE_LO_RST;
            st_r.state <= ST_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    sticky_bits #(
        .WIDTH(4)
    ) u_irq_stat (
        .core_clk(core_clk),
        .nrst(nrst),
        .set(ev_set),
        .clr(ev_clr),
        .stat(irq_stat)
    );

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdat;
    assign start_accept_flag = st_r.accept;
    assign speed_controlling_flag = st_r.spd_flag;
    assign positioning_complete_flag = st_r.done_flag;
    assign error_detection_flag = st_r.err_flag;
    assign servo_step = st_r.step;
    assign servo_dir = st_r.dir;
    assign irq = st_r.irq;

    // ==========================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
    speed_flag_a: assert property (speed_controlling_flag |-> st_r.state == ST_SPEED)
        else $error("speed flag outside speed mode");
    direct_pos_a: assert property (st_r.state == ST_IDLE && st_nxt.state == ST_POSITION
        |=> !speed_controlling_flag)
        else $error("speed flag raised on direct position start");
    feed_clear_a: assert property (st_r.state == ST_IDLE && st_nxt.state != ST_IDLE
        && !st_r.ctrl[`CTRL_UPDATE] |=> st_r.feed == 32'h00000000)
        else $error("feed not cleared at start");
    switch_gate_a: assert property (st_r.state == ST_SPEED && st_nxt.state == ST_POSITION
        |-> sw_edge && st_r.ctrl[`CTRL_ENABLE])
        else $error("mode change without qualified switch");
    overrun_a: assert property ($rose(error_detection_flag) && st_r.err_code == `ERR_OVERRUN
        |-> st_r.state == ST_DECEL && !positioning_complete_flag)
        else $error("overrun without deceleration");
    no_done_a: assert property (st_r.state == ST_DECEL |=> !$rose(positioning_complete_flag))
        else $error("complete flag after overrun");
    speed_stroke_a: assert property (st_r.state == ST_SPEED && !sw_edge
        |=> !$rose(error_detection_flag))
        else $error("stroke checked in speed mode");
    err_hold_a: assert property (error_detection_flag
        && !(wr && idx == `IDX_CMD && wb_sel_i[0] && wb_dat_i[`CMD_ERRCLR])
        |=> error_detection_flag)
        else $error("error flag dropped without clear");
    fwd_dir_a: assert property (tick && st_r.state == ST_SPEED && !st_r.dir
        |=> st_r.feed == $past(st_r.feed) + 32'($past(st_r.cur_spd)))
        else $error("forward move did not increase feed");
endmodule // sps_axis

/* sps_partner.sv */
// switch sensor and servo amplifier model for the switching axis
`timescale 1ns/10ps
module sps_partner (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic actuated,
    input wire logic nc_contact,
    input wire logic [15:0] servo_step,
    output logic change_in,
    output logic moving
);
    // a normally closed contact opens when the switch is actuated
    assign change_in = nc_contact ? ~actuated : actuated;
    // amplifier sees motion while pulses are being issued
    assign moving = nrst && (servo_step != 16'h0000);
endmodule // sps_partner

/* test_speed_position_switching_axis.sv */
// self-checking testbench for the speed/position switching axis
`timescale 1ns/10ps
`include "sps_params.svh"
module test_speed_position_switching_axis;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] dat_i = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic actuated = 1'b0;
    logic nc_contact = 1'b0;
    logic [31:0] dat_o;
    logic ack, change_in, sa_f, spd_f, done_f, err_f, servo_dir, irq, moving;
    logic [15:0] servo_step;
    logic [31:0] q, q2, dat2, feed1;
    int err_count = 0;
    int num_checks = 0;
    sps_axis dut_u (.core_clk(core_clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(dat_i),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .change_in(change_in), .start_accept_flag(sa_f),
        .speed_controlling_flag(spd_f), .positioning_complete_flag(done_f),
        .error_detection_flag(err_f), .servo_step(servo_step), .servo_dir(servo_dir),
        .irq(irq));
    sps_partner partner_u (.core_clk(core_clk), .nrst(nrst), .actuated(actuated),
        .nc_contact(nc_contact), .servo_step(servo_step), .change_in(change_in),
        .moving(moving));
    // small variant on axis nine: travel registers must not exist
    sps_axis #(.AXIS_NUM(9), .LARGE_VARIANT(1'b0)) small_u (.core_clk(core_clk), .nrst(nrst),
        .wb_adr_i(adr), .wb_dat_i(dat_i), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(dat2), .wb_ack_o(), .change_in(change_in),
        .start_accept_flag(), .speed_controlling_flag(), .positioning_complete_flag(),
        .error_detection_flag(), .servo_step(), .servo_dir(), .irq());
    // ==========================================
    // helpers
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [10:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {19'h00000, idx, 2'b00};
        dat_i <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk_bit("wb_ack_o", 1'b1, ack);
        q = dat_o;
        q2 = dat2;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk_rd(input string nm, input logic [10:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 32'h0);
        chk_reg(nm, e, q);
    endtask
    task automatic ticks(input int n);
        repeat (n * `CTRL_CYCLES) @(negedge core_clk);
    endtask
    task automatic sense(input logic v);
        @(posedge core_clk);
        actuated <= v;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (sa_f !== 1'b0 && n < 20000);
        chk_bit("start_accept_flag", 1'b0, sa_f);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk_rd("SPEED", `IDX_SPEED, 32'h00000010);
        chk_rd("STROKE_HI", `IDX_STROKE_HI, 32'h7FFFFFFF);
        chk_rd("STROKE_LO", `IDX_STROKE_LO, 32'h80000000);
        chk_rd("STATUS", `IDX_STATUS, 32'h00000000);
        wb(1'b1, 11'h3FF, 32'hFFFFFFFF);
        chk_rd("unmapped", 11'h3FF, 32'h00000000);
        wb(1'b1, `IDX_TRAVEL_BASE + 11'h001, 32'h0000ABCD);
        chk_rd("TRAVEL_HI", `IDX_TRAVEL_BASE + 11'h001, 32'h0000ABCD);
        wb(1'b1, 11'h0B0, 32'h00001234);
        chk_rd("axis9 travel on axis1", 11'h0B0, 32'h00000000);
        chk_reg("small variant travel", 32'h00000000, q2);
    endtask
    task automatic t_normal();
        wb(1'b1, `IDX_SPEED, 32'h00000008);
        wb(1'b1, `IDX_CTRL, 32'h00000002);
        wb(1'b1, `IDX_TRAVEL_BASE, 32'h00000064);
        wb(1'b1, `IDX_TRAVEL_BASE + 11'h001, 32'h00000000);
        wb(1'b1, `IDX_IRQ_MASK, 32'h00000002);
        wb(1'b1, `IDX_CMD, 32'h00000001);
        @(negedge core_clk);
        chk_bit("speed_controlling_flag", 1'b1, spd_f);
        chk_bit("servo_dir", 1'b0, servo_dir);
        ticks(3);
        chk_bit("moving", 1'b1, moving);
        wb(1'b1, `IDX_TRAVEL_BASE, 32'h000000C8);
        sense(1'b1);
        wait_idle();
        chk_bit("positioning_complete_flag", 1'b1, done_f);
        chk_rd("POSTPROX", `IDX_POSTPROX, 32'h000000C8);
        @(negedge core_clk);
        chk_bit("moving", 1'b0, moving);
        chk_bit("irq", 1'b1, irq);
        wb(1'b0, `IDX_FEED, 32'h0);
        feed1 = q;
        chk_bit("feed tracked", 1'b1, $signed(feed1) > 200);
        wb(1'b1, `IDX_IRQ_STAT, 32'h00000002);
        repeat (2) @(negedge core_clk);
        chk_bit("irq", 1'b0, irq);
        sense(1'b0);
    endtask
    task automatic t_stroke();
        wb(1'b1, `IDX_CTRL, 32'h00000006);
        wb(1'b1, `IDX_STROKE_HI, feed1 + 32'h14);
        wb(1'b1, `IDX_CMD, 32'h00000001);
        wb(1'b0, `IDX_FEED, 32'h0);
        chk_bit("feed kept", 1'b1, $signed(q) >= $signed(feed1));
        ticks(8);
        chk_bit("error_detection_flag", 1'b0, err_f);
        chk_bit("speed_controlling_flag", 1'b1, spd_f);
        sense(1'b1);
        wait_idle();
        chk_bit("error_detection_flag", 1'b1, err_f);
        chk_rd("ERRCODE", `IDX_ERRCODE, 32'h000000D2);
        chk_bit("positioning_complete_flag", 1'b0, done_f);
        chk_bit("irq masked", 1'b0, irq);
        wb(1'b1, `IDX_IRQ_MASK, 32'h00000008);
        repeat (2) @(negedge core_clk);
        chk_bit("irq", 1'b1, irq);
        wb(1'b1, `IDX_IRQ_STAT, 32'h0000000F);
        repeat (2) @(negedge core_clk);
        chk_bit("irq", 1'b0, irq);
        ticks(2);
        chk_bit("error_detection_flag", 1'b1, err_f);
        wb(1'b1, `IDX_CMD, 32'h00000008);
        @(negedge core_clk);
        chk_bit("error_detection_flag", 1'b0, err_f);
        wb(1'b1, `IDX_STROKE_HI, 32'h7FFFFFFF);
        sense(1'b0);
    endtask
    task automatic t_overrun_nc();
        nc_contact <= 1'b1;
        wb(1'b1, `IDX_CTRL, 32'h00000003);
        wb(1'b1, `IDX_TRAVEL_BASE, 32'h0000000A);
        wb(1'b1, `IDX_CMD, 32'h00000001);
        wb(1'b0, `IDX_FEED, 32'h0);
        chk_bit("feed cleared", 1'b1, $signed(q) <= 16);
        ticks(3);
        chk_bit("speed_controlling_flag", 1'b1, spd_f);
        sense(1'b1);
        ticks(2);
        wb(1'b0, `IDX_STATUS, 32'h0);
        chk_reg("state", 32'h3, {30'h0, q[6:5]});
        wait_idle();
        chk_bit("error_detection_flag", 1'b1, err_f);
        chk_rd("ERRCODE", `IDX_ERRCODE, 32'h000000D1);
        chk_bit("positioning_complete_flag", 1'b0, done_f);
        wb(1'b1, `IDX_CMD, 32'h00000008);
        wb(1'b1, `IDX_IRQ_STAT, 32'h0000000F);
        sense(1'b0);
        nc_contact <= 1'b0;
    endtask
    task automatic t_late_enable();
        wb(1'b1, `IDX_CTRL, 32'h00000000);
        sense(1'b1);
        wb(1'b1, `IDX_CMD, 32'h00000002);
        ticks(2);
        wb(1'b1, `IDX_CTRL, 32'h00000002);
        ticks(3);
        chk_bit("speed_controlling_flag", 1'b1, spd_f);
        chk_bit("servo_dir", 1'b1, servo_dir);
        wb(1'b1, `IDX_CMD, 32'h00000004);
        wait_idle();
        chk_bit("error_detection_flag", 1'b0, err_f);
        chk_bit("positioning_complete_flag", 1'b0, done_f);
    endtask
    task automatic t_direct();
        logic seen;
        seen = 1'b0;
        wb(1'b1, `IDX_TRAVEL_BASE, 32'h00000064);
        wb(1'b1, `IDX_CMD, 32'h00000001);
        repeat (300)
        begin
            @(negedge core_clk);
            seen = seen | (spd_f !== 1'b0);
        end
        chk_bit("speed flag seen", 1'b0, seen);
        wb(1'b0, `IDX_STATUS, 32'h0);
        chk_reg("state", 32'h2, {30'h0, q[6:5]});
        wait_idle();
        chk_bit("positioning_complete_flag", 1'b1, done_f);
        sense(1'b0);
    endtask
    // ==========================================
    // run control
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        #400000;
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_normal();
        t_stroke();
        t_overrun_nc();
        t_late_enable();
        t_direct();
        wrap_up();
    end
endmodule // test_speed_position_switching_axis
